/* File: core/uart_cmd_pkg.sv */
// Overview of operation
// RULE1 - Code 1001 drives request to send high
// RULE2 - Timeout mode restarts counter per received character
// RULE3 - Timeout entry: counter mode, stop, clear ready
// RULE4 - Either receiver's transfer restarts the shared counter
// RULE5 - Code 1011 points mode access at register zero
// RULE6 - Code 1100 returns start/stop control, nothing else
// RULE7 - Host stops counter after leaving timeout mode
// RULE8 - Code 1101 enables block error accumulation
// RULE9 - Block errors cleared only by receiver reset
// RULE10 - Host never issues codes 111x
// RULE11 - Fixed rates hold only from 3.6864MHz crystal
// RULE12 - Upper nibble picks receive clock, 1111 external 1X
// RULE13 - Lower nibble: 1110 external 16X, 1111 external 1X
// RULE14 - Rate set bit picks one of two rate sets
// RULE15 - Transmit disable clears flags, drains queued characters
// RULE16 - Disabled or draining transmitter refuses queue loads
// RULE17 - Transmit enable sets ready and empty flags
// RULE18 - Receive disable aborts character, keeps queue, status
// RULE19 - Wake-up mode keeps receiver running while disabled
// RULE20 - Receive enable forces start-bit search unless wake-up
// RULE21 - Host spaces upper-nibble commands three crystal edges
// RULE22 - Code 0010 resets and disables receiver, queue pointer
// RULE23 - One write acts on code and enable bits together
`default_nettype none
package uart_cmd_pkg;
	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] channel_command_addr = 8'h00;
	localparam logic [7:0] clock_select_addr = 8'h04;
	localparam logic [7:0] auxiliary_control_addr = 8'h08;
	localparam logic [7:0] channel_state_addr = 8'h0c;
	// ==========================================================
	// Reset values
	localparam logic [7:0] clock_select_reset = 8'h00;
	localparam logic [2:0] auxiliary_control_reset = 3'h0;
	// ==========================================================
	// Channel command fields
	localparam int command_code_lsb = 4;
	localparam int disable_tx_bit = 3;
	localparam int enable_tx_bit = 2;
	localparam int disable_rx_bit = 1;
	localparam int enable_rx_bit = 0;
	localparam logic [3:0] cmd_mode_pointer_one = 4'h1;
	localparam logic [3:0] cmd_reset_receiver = 4'h2;
	localparam logic [3:0] cmd_reset_transmitter = 4'h3;
	localparam logic [3:0] cmd_assert_rts = 4'h8;
	localparam logic [3:0] cmd_negate_rts = 4'h9;
	localparam logic [3:0] cmd_timeout_on = 4'ha;
	localparam logic [3:0] cmd_mode_pointer_zero = 4'hb;
	localparam logic [3:0] cmd_timeout_off = 4'hc;
	localparam logic [3:0] cmd_block_error = 4'hd;
	localparam logic [2:0] cmd_test_prefix = 3'h7;
	// ==========================================================
	// Clock select fields and codes
	localparam int rx_select_lsb = 4;
	localparam int tx_select_lsb = 0;
	localparam logic [3:0] sel_timer = 4'hd;
	localparam logic [3:0] sel_external_16x = 4'he;
	localparam logic [3:0] sel_external_1x = 4'hf;
	// ==========================================================
	// Auxiliary control fields
	localparam int rate_set_bit = 0;
	localparam int rate_group_bit = 1;
	localparam int wake_up_bit = 2;
	localparam int crystal_hz = 3686400;
	// ==========================================================
	// Mode register pointer values
	localparam logic [1:0] mode_register_zero = 2'h0;
	localparam logic [1:0] mode_register_one = 2'h1;
	localparam logic [1:0] mode_register_last = 2'h2;
	// ==========================================================
	// Types
	typedef enum logic [1:0]
	{
		src_baud_generator = 2'h0,
		src_timer = 2'h1,
		src_external_16x = 2'h2,
		src_external_1x = 2'h3
	} clock_source_type;
	typedef enum logic [2:0]
	{
		tx_off = 3'b001,
		tx_on = 3'b010,
		tx_drain = 3'b100
	} tx_state_type;
endpackage : uart_cmd_pkg
`default_nettype wire

/* File: core/uart_channel_command.sv */
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module uart_channel_command
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Modem control
	output logic request_to_send_n,
	// Receiver side
	input wire logic rx_transfer,
	input wire logic other_rx_transfer,
	output logic rx_enabled,
	output logic rx_active,
	output logic rx_abort,
	output logic rx_hunt,
	output logic rx_reset,
	output logic block_error_mode,
	// Transmitter side
	input wire logic tx_busy,
	input wire logic tx_write_request,
	output logic tx_write_accept,
	output logic tx_reset,
	output logic transmit_ready_flag,
	output logic transmit_empty_flag,
	output logic tx_running,
	// Mode register access
	input wire logic mode_access,
	output logic [1:0] mode_register_pointer,
	// Counter/timer control
	output logic timeout_mode,
	output logic counter_restart,
	output logic counter_stop,
	output logic counter_ready_clear,
	// Bit clock selection
	output uart_cmd_pkg::clock_source_type rx_clock_source,
	output uart_cmd_pkg::clock_source_type tx_clock_source,
	output logic [3:0] rx_rate_code,
	output logic [3:0] tx_rate_code,
	output logic rate_set,
	output logic rate_group
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// Bus slave
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire write_fire = aw_held && w_held && !s_axi_bvalid;
	wire addr_cmd = aw_addr == uart_cmd_pkg::channel_command_addr;
	wire addr_csel = aw_addr == uart_cmd_pkg::clock_select_addr;
	wire addr_aux = aw_addr == uart_cmd_pkg::auxiliary_control_addr;
	wire addr_state = aw_addr == uart_cmd_pkg::channel_state_addr;
	wire write_known = addr_cmd || addr_csel || addr_aux || addr_state;
	wire cmd_write = write_fire && addr_cmd && w_strb[0];
	wire csel_write = write_fire && addr_csel && w_strb[0];
	wire aux_write = write_fire && addr_aux && w_strb[0];

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (w_take)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (write_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= write_known ? 2'h0 : 2'h2;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};
	wire rd_state = rd_addr == uart_cmd_pkg::channel_state_addr;
	wire rd_aux = rd_addr == uart_cmd_pkg::auxiliary_control_addr;
	wire rd_wo = rd_addr == uart_cmd_pkg::channel_command_addr
		|| rd_addr == uart_cmd_pkg::clock_select_addr;
	wire rd_known = rd_state || rd_aux || rd_wo;
	wire [31:0] state_word;
	wire [31:0] aux_word;
	wire [31:0] next_rdata = rd_state ? state_word
		: (rd_aux ? aux_word : 32'h0);

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// Command decode
	wire [3:0] code = w_data[uart_cmd_pkg::command_code_lsb +: 4];
	wire test_code = code[3:1] == uart_cmd_pkg::cmd_test_prefix; // RULE10
	wire do_cmd = cmd_write && !test_code; // RULE10
	wire do_rx_reset = do_cmd && code == uart_cmd_pkg::cmd_reset_receiver;
	wire do_tx_reset = do_cmd && code == uart_cmd_pkg::cmd_reset_transmitter;
	wire do_timeout_on = do_cmd && code == uart_cmd_pkg::cmd_timeout_on;
	wire do_timeout_off = do_cmd && code == uart_cmd_pkg::cmd_timeout_off;
	wire do_tx_disable = cmd_write
		&& w_data[uart_cmd_pkg::disable_tx_bit]; // RULE23
	wire do_tx_enable = cmd_write && w_data[uart_cmd_pkg::enable_tx_bit]
		&& !do_tx_disable; // RULE23
	wire do_rx_disable = cmd_write
		&& w_data[uart_cmd_pkg::disable_rx_bit]; // RULE23
	wire do_rx_enable = cmd_write && w_data[uart_cmd_pkg::enable_rx_bit]
		&& !do_rx_disable && !do_rx_reset; // RULE23

	// ==========================================================
	// Control state
	logic [2:0] aux;
	logic [7:0] clock_select;
	wire wake_up = aux[uart_cmd_pkg::wake_up_bit];

	assign rate_set = aux[uart_cmd_pkg::rate_set_bit]; // RULE14
	assign rate_group = aux[uart_cmd_pkg::rate_group_bit]; // RULE14
	assign aux_word = {29'h0, aux};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aux <= uart_cmd_pkg::auxiliary_control_reset;
			clock_select <= uart_cmd_pkg::clock_select_reset;
			request_to_send_n <= 1'b1;
			timeout_mode <= 1'b0;
			block_error_mode <= 1'b0;
			mode_register_pointer <= uart_cmd_pkg::mode_register_one;
		end
		else
		begin
			if (aux_write)
				aux <= w_data[2:0];
			if (csel_write)
				clock_select <= w_data[7:0];
			if (do_cmd && code == uart_cmd_pkg::cmd_assert_rts)
				request_to_send_n <= 1'b0;
			else if (do_cmd && code == uart_cmd_pkg::cmd_negate_rts)
				request_to_send_n <= 1'b1; // RULE1
			if (do_timeout_on)
				timeout_mode <= 1'b1; // RULE3
			else if (do_timeout_off)
				timeout_mode <= 1'b0; // RULE6
			if (do_rx_reset)
				block_error_mode <= 1'b0; // RULE9
			else if (do_cmd && code == uart_cmd_pkg::cmd_block_error)
				block_error_mode <= 1'b1; // RULE8
			if (do_cmd && code == uart_cmd_pkg::cmd_mode_pointer_zero)
				mode_register_pointer <=
					uart_cmd_pkg::mode_register_zero; // RULE5
			else if (do_cmd && code == uart_cmd_pkg::cmd_mode_pointer_one)
				mode_register_pointer <= uart_cmd_pkg::mode_register_one;
			else if (mode_access && mode_register_pointer
				!= uart_cmd_pkg::mode_register_last)
				mode_register_pointer <= mode_register_pointer + 2'h1;
		end
	end

	// ==========================================================
	// Counter/timer control pulses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			counter_stop <= 1'b0;
			counter_ready_clear <= 1'b0;
			counter_restart <= 1'b0;
		end
		else
		begin
			counter_stop <= do_timeout_on; // RULE3
			counter_ready_clear <= do_timeout_on; // RULE3
			counter_restart <= timeout_mode && !do_timeout_off
				&& (rx_transfer || other_rx_transfer); // RULE2 RULE4
		end
	end

	// ==========================================================
	// Receiver control
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_enabled <= 1'b0;
			rx_abort <= 1'b0;
			rx_hunt <= 1'b0;
			rx_reset <= 1'b0;
		end
		else
		begin
			rx_reset <= do_rx_reset; // RULE22
			rx_abort <= do_rx_disable && rx_enabled && !wake_up; // RULE18
			rx_hunt <= do_rx_enable && !wake_up; // RULE20
			if (do_rx_reset || do_rx_disable)
				rx_enabled <= 1'b0; // RULE18 RULE22
			else if (do_rx_enable)
				rx_enabled <= 1'b1; // RULE20
		end
	end

	assign rx_active = rx_enabled || wake_up; // RULE19

	// ==========================================================
	// Transmitter control
	uart_cmd_pkg::tx_state_type tx_state;
	uart_cmd_pkg::tx_state_type next_tx_state;

	always_comb
	begin
		next_tx_state = tx_state;
		unique case (tx_state)
			uart_cmd_pkg::tx_off:
				if (do_tx_enable)
					next_tx_state = uart_cmd_pkg::tx_on;
			uart_cmd_pkg::tx_on:
				if (do_tx_disable)
					next_tx_state = tx_busy ? uart_cmd_pkg::tx_drain
						: uart_cmd_pkg::tx_off; // RULE15
			uart_cmd_pkg::tx_drain:
				if (do_tx_enable)
					next_tx_state = uart_cmd_pkg::tx_on;
				else if (!tx_busy)
					next_tx_state = uart_cmd_pkg::tx_off; // RULE15
			default:
				next_tx_state = uart_cmd_pkg::tx_off;
		endcase
		if (do_tx_reset)
			next_tx_state = uart_cmd_pkg::tx_off;
	end

	assign tx_write_accept = tx_write_request
		&& tx_state == uart_cmd_pkg::tx_on && transmit_ready_flag; // RULE16
	assign tx_running = tx_state != uart_cmd_pkg::tx_off;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state <= uart_cmd_pkg::tx_off;
			transmit_ready_flag <= 1'b0;
			transmit_empty_flag <= 1'b0;
			tx_reset <= 1'b0;
		end
		else
		begin
			tx_state <= next_tx_state;
			tx_reset <= do_tx_reset;
			if (do_tx_disable || do_tx_reset)
			begin
				transmit_ready_flag <= 1'b0; // RULE15
				transmit_empty_flag <= 1'b0; // RULE15
			end
			else if (do_tx_enable)
			begin
				transmit_ready_flag <= 1'b1; // RULE17
				transmit_empty_flag <= 1'b1; // RULE17
			end
			else if (tx_write_accept)
				transmit_empty_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Bit clock selection
	function automatic uart_cmd_pkg::clock_source_type source_of
	(
		input logic [3:0] sel
	);
		if (sel == uart_cmd_pkg::sel_external_1x)
			source_of = uart_cmd_pkg::src_external_1x;
		else if (sel == uart_cmd_pkg::sel_external_16x)
			source_of = uart_cmd_pkg::src_external_16x;
		else if (sel == uart_cmd_pkg::sel_timer)
			source_of = uart_cmd_pkg::src_timer;
		else
			source_of = uart_cmd_pkg::src_baud_generator;
	endfunction : source_of

	assign rx_rate_code = clock_select[uart_cmd_pkg::rx_select_lsb +: 4];
	assign tx_rate_code = clock_select[uart_cmd_pkg::tx_select_lsb +: 4];
	// Fixed rates assume the crystal_hz reference clock
	assign rx_clock_source = source_of(rx_rate_code); // RULE11 RULE12
	assign tx_clock_source = source_of(tx_rate_code); // RULE13 RULE14

	assign state_word = {19'h0, rate_group, rate_set, block_error_mode,
		timeout_mode, mode_register_pointer, request_to_send_n,
		tx_state == uart_cmd_pkg::tx_drain, tx_running, rx_active,
		rx_enabled, transmit_empty_flag, transmit_ready_flag};

	// ==========================================================
	// Assertions
	negate_rts_a: assert property (do_cmd // RULE1
		&& code == uart_cmd_pkg::cmd_negate_rts |=> request_to_send_n)
		else $error("request to send not negated");
	timeout_restart_a: assert property (timeout_mode // RULE2 RULE4
		&& !do_timeout_off && (rx_transfer || other_rx_transfer)
		|=> counter_restart) else $error("counter not restarted");
	timeout_entry_a: assert property (do_timeout_on // RULE3
		|=> counter_stop && counter_ready_clear && timeout_mode)
		else $error("timeout entry incomplete");
	timeout_exit_a: assert property (do_timeout_off // RULE6
		|=> !counter_stop && !counter_ready_clear && !timeout_mode)
		else $error("timeout exit touched counter");
	pointer_zero_a: assert property (do_cmd // RULE5
		&& code == uart_cmd_pkg::cmd_mode_pointer_zero
		|=> mode_register_pointer == uart_cmd_pkg::mode_register_zero)
		else $error("mode pointer not zero");
	block_hold_a: assert property (block_error_mode // RULE9
		&& !do_rx_reset |=> block_error_mode)
		else $error("block error mode cleared");
	tx_disable_a: assert property (do_tx_disable // RULE15 RULE16
		|=> !transmit_ready_flag && !transmit_empty_flag && !tx_write_accept)
		else $error("disable did not clear flags");
	tx_drain_a: assert property (tx_state == uart_cmd_pkg::tx_on // RULE15
		&& do_tx_disable && tx_busy && !do_tx_reset |=> tx_running)
		else $error("transmitter stopped before draining");
	tx_enable_a: assert property (do_tx_enable && !do_tx_reset // RULE17
		|=> transmit_ready_flag && transmit_empty_flag)
		else $error("enable did not set flags");
	rx_enable_a: assert property (do_rx_enable // RULE20
		|=> rx_enabled && (rx_hunt == !wake_up))
		else $error("receiver enable wrong");
	rx_reset_a: assert property (do_rx_reset // RULE22 RULE9
		|=> rx_reset && !rx_enabled && !block_error_mode)
		else $error("receiver reset incomplete");
	wake_a: assert property (wake_up |-> rx_active) // RULE19
		else $error("wake-up receiver inactive");
	clock_sel_a: assert property ( // RULE13
		tx_rate_code == uart_cmd_pkg::sel_external_16x
		|-> tx_clock_source == uart_cmd_pkg::src_external_16x)
		else $error("transmit external clock not chosen");
endmodule : uart_channel_command
`default_nettype wire

/* File: dv/uart_line_model.sv */
`default_nettype none
module uart_line_model
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Requests from the bench
	input wire logic send_rx,
	input wire logic send_other,
	input wire logic drain_one,
	// Block status
	input wire logic rx_active,
	input wire logic tx_write_accept,
	// Line events
	output logic rx_transfer,
	output logic other_rx_transfer,
	output logic tx_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Serial engine stand-in
	logic [3:0] queued;
	assign tx_busy = queued != 4'h0;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			queued <= 4'h0;
			rx_transfer <= 1'b0;
			other_rx_transfer <= 1'b0;
		end
		else
		begin
			// This receiver's transfers occur only while rx_active; other_rx_transfer is not gated
			rx_transfer <= send_rx & rx_active;
			other_rx_transfer <= send_other;
			queued <= queued + 4'(tx_write_accept)
				- 4'(drain_one & tx_busy);
		end
	end
endmodule : uart_line_model
`default_nettype wire

/* File: dv/uart_channel_command_test.sv */
`default_nettype none
module uart_channel_command_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, strb, rx_rate_code, tx_rate_code;
	logic [1:0] s_axi_bresp, s_axi_rresp, mode_register_pointer;
	logic request_to_send_n, rx_transfer, other_rx_transfer, rx_enabled;
	logic rx_active, rx_abort, rx_hunt, rx_reset, block_error_mode;
	logic tx_busy, tx_write_request, tx_write_accept, tx_reset;
	logic transmit_ready_flag, transmit_empty_flag, tx_running;
	logic mode_access, timeout_mode, counter_restart, counter_stop;
	logic counter_ready_clear, rate_set, rate_group;
	logic send_rx, send_other, drain_one;
	logic [5:0] snap;
	uart_cmd_pkg::clock_source_type rx_clock_source, tx_clock_source;
	int num_errors = 0;
	int compares = 0;
	localparam logic [7:0] cmd = uart_cmd_pkg::channel_command_addr;
	localparam logic [7:0] aux = uart_cmd_pkg::auxiliary_control_addr;
	localparam logic [7:0] csr_tab [5] = '{8'h00, 8'hdd, 8'hee, 8'hff, 8'h5e};
	// Expected sources: 0 generator, 1 timer, 2 external 16X, 3 external 1X
	localparam logic [1:0] rx_exp [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
	localparam logic [1:0] tx_exp [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
	uart_channel_command i_uart_channel_command
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .request_to_send_n, .rx_transfer,
		.other_rx_transfer, .rx_enabled, .rx_active, .rx_abort, .rx_hunt,
		.rx_reset, .block_error_mode, .tx_busy, .tx_write_request,
		.tx_write_accept, .tx_reset, .transmit_ready_flag,
		.transmit_empty_flag, .tx_running, .mode_access,
		.mode_register_pointer, .timeout_mode, .counter_restart,
		.counter_stop, .counter_ready_clear, .rx_clock_source,
		.tx_clock_source, .rx_rate_code, .tx_rate_code, .rate_set,
		.rate_group
	);
	uart_line_model i_uart_line_model
	(
		.aclk, .aresetn, .send_rx, .send_other, .drain_one, .rx_active,
		.tx_write_accept, .rx_transfer, .other_rx_transfer, .tx_busy
	);
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ==========================================================
	// Compare and report
	task automatic check_word(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %0t ns: got %h expected %h", $time, g, e);
		end
	endtask : check_word
	task automatic check_flag(input logic g, input logic e);
		check_word({31'h0, g}, {31'h0, e});
	endtask : check_flag
	task automatic done(input string name);
		$display("test %s ended", name);
	endtask : done
	task automatic stop_test;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		snap = {rx_abort, rx_hunt, rx_reset, tx_reset, counter_stop,
			counter_ready_clear};
		s_axi_bready <= 1'b0;
		check_word({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check_word(s_axi_rdata, ed);
		check_word({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd
	// ==========================================================
	// Line and queue helpers
	task automatic pulse_rx(input logic other, input logic exp);
		logic seen;
		@(posedge aclk);
		send_rx <= !other;
		send_other <= other;
		@(posedge aclk);
		send_rx <= 1'b0;
		send_other <= 1'b0;
		seen = 1'b0;
		repeat (4)
		begin
			@(posedge aclk);
			seen = seen | counter_restart;
		end
		check_flag(seen, exp);
	endtask : pulse_rx
	task automatic tx_load(input logic exp);
		@(posedge aclk);
		tx_write_request <= 1'b1;
		@(posedge aclk);
		tx_write_request <= 1'b0;
		check_flag(tx_write_accept, exp);
	endtask : tx_load
	// ==========================================================
	// Tests
	initial
	begin
		#100000;
		num_errors++;
		stop_test();
	end
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, tx_write_request, mode_access, send_rx} = 4'h0;
		{send_other, drain_one, aresetn} = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		strb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(uart_cmd_pkg::channel_state_addr, 32'h000000c0, 2'h0);
		rd(cmd, 32'h0, 2'h0);
		rd(8'h10, 32'h0, 2'h2);
		wr(8'h10, 8'h80, 2'h2);
		check_flag(request_to_send_n, 1'b1);
		done("reset");
		wr(cmd, 8'h80, 2'h0);
		check_flag(request_to_send_n, 1'b0);
		wr(cmd, 8'h90, 2'h0);
		check_flag(request_to_send_n, 1'b1);
		strb = 4'he;
		wr(cmd, 8'h80, 2'h0);
		strb = 4'hf;
		check_flag(request_to_send_n, 1'b1);
		wr(cmd, 8'hb0, 2'h0);
		check_word({30'h0, mode_register_pointer}, 32'h0);
		repeat (3)
		begin
			@(posedge aclk);
			mode_access <= 1'b1;
			@(posedge aclk);
			mode_access <= 1'b0;
		end
		@(posedge aclk);
		check_word({30'h0, mode_register_pointer}, 32'h2);
		wr(cmd, 8'hb0, 2'h0);
		check_word({30'h0, mode_register_pointer}, 32'h0);
		done("pointer");
		wr(cmd, 8'h85, 2'h0);
		check_word({26'h0, snap}, 32'h10);
		check_flag(request_to_send_n, 1'b0);
		check_flag(transmit_ready_flag & rx_enabled, 1'b1);
		wr(cmd, 8'h02, 2'h0);
		check_word({26'h0, snap}, 32'h20);
		check_flag(rx_enabled | rx_active, 1'b0);
		wr(aux, 8'h04, 2'h0);
		check_flag(rx_active, 1'b1);
		wr(cmd, 8'h01, 2'h0);
		check_word({26'h0, snap}, 32'h0);
		wr(cmd, 8'h02, 2'h0);
		check_word({26'h0, snap}, 32'h0);
		wr(aux, 8'h00, 2'h0);
		done("receiver");
		wr(cmd, 8'h01, 2'h0);
		wr(cmd, 8'ha0, 2'h0);
		check_word({26'h0, snap}, 32'h03);
		check_flag(timeout_mode, 1'b1);
		pulse_rx(1'b0, 1'b1);
		pulse_rx(1'b1, 1'b1);
		wr(cmd, 8'hc0, 2'h0);
		check_word({26'h0, snap}, 32'h0);
		check_flag(timeout_mode, 1'b0);
		pulse_rx(1'b0, 1'b0);
		done("timeout");
		wr(cmd, 8'hd0, 2'h0);
		check_flag(block_error_mode, 1'b1);
		wr(cmd, 8'h32, 2'h0);
		check_flag(block_error_mode, 1'b1);
		wr(cmd, 8'h21, 2'h0);
		check_word({26'h0, snap}, 32'h08);
		check_flag(block_error_mode | rx_enabled, 1'b0);
		wr(cmd, 8'h40, 2'h0);
		wr(cmd, 8'h00, 2'h0);
		check_word({26'h0, snap}, 32'h0);
		check_flag(request_to_send_n, 1'b0);
		done("block");
		wr(cmd, 8'h04, 2'h0);
		check_flag(transmit_ready_flag & transmit_empty_flag, 1'b1);
		tx_load(1'b1);
		wr(cmd, 8'h08, 2'h0);
		check_flag(transmit_ready_flag | transmit_empty_flag, 1'b0);
		check_flag(tx_running, 1'b1);
		tx_load(1'b0);
		@(posedge aclk);
		drain_one <= 1'b1;
		@(posedge aclk);
		drain_one <= 1'b0;
		repeat (3) @(posedge aclk);
		check_flag(tx_running, 1'b0);
		tx_load(1'b0);
		done("transmitter");
		foreach (csr_tab[i])
		begin
			wr(uart_cmd_pkg::clock_select_addr, csr_tab[i], 2'h0);
			check_word({30'h0, rx_clock_source}, {30'h0, rx_exp[i]});
			check_word({30'h0, tx_clock_source}, {30'h0, tx_exp[i]});
			check_word({24'h0, rx_rate_code, tx_rate_code},
				{24'h0, csr_tab[i]});
		end
		wr(aux, 8'h03, 2'h0);
		check_flag(rate_set & rate_group, 1'b1);
		done("clocks");
		stop_test();
	end
endmodule : uart_channel_command_test
`default_nettype wire
